// [verification/tb_paging_binary_message_parser.sv]
// Self-checking bench for the transparent paging message parser.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_paging_binary_message_parser
    import pager_bin_pkg::*;
();
    logic       ref_clk = 1'b0;
    logic       arst_n  = 1'b0;
    word_in_t   word_in;
    logic       word_ready;
    hdr_out_t   hdr_out;
    char_out_t  char_out;
    status_t    status;
    hdr_out_t   exp_hdr[$];
    logic [3:0] exp_chr[$];
    status_t    exp_st[$];
    hdr_out_t   eh;
    logic [3:0] ec;
    status_t    es;
    integer     seed = 32'hcb3feafe;
    int         num_errors = 0;
    int         tests_run = 0;
    logic       prev_hdr = 1'b0;
    logic [5:0] prev_num = 6'h00;

    paging_binary_message_parser dut (
        .REF_CLK   (ref_clk),
        .ARST_N    (arst_n),
        .WORD_IN   (word_in),
        .WORD_READY(word_ready),
        .HDR_OUT   (hdr_out),
        .CHAR_OUT  (char_out),
        .STATUS    (status)
    );

    word_source src (.clk(ref_clk), .ready(word_ready), .word(word_in));

    always #25 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // Builds one message fragment by fragment, noting each fragment's expected outputs before handing its words to the source.
    // Fault 1 spoils the first checksum, 2 the signature, 3 the second fragment number.
    task automatic send_msg(input logic [5:0] num, input logic [3:0] blk, input logic hf,
                            input logic df, input int nch, input int nfr, input int fault);
        logic [3:0]        ch[$];
        logic [INFO_W-1:0] w[$];
        logic [INFO_W-1:0] hw;
        logic [INFO_W-1:0] cur;
        logic [7:0]        sig;
        logic [11:0]       ks;
        logic [1:0]        fn;
        logic              bv;
        logic              fe;
        logic              lst;
        int                per;
        int                c0;
        int                cn;
        int                k;
        sig = 8'h00;
        fe = 1'b0;
        bv = 1'b0;
        for (int i = 0; i < nch; i++) ch.push_back(4'($random(seed)));
        for (int i = 0; i < nch; i += 2)
            sig += (i + 1 < nch) ? {ch[i + 1], ch[i]} : {4'h0, ch[i]};
        sig = ~sig;
        hw = {sig ^ 8'(fault == 2), 5'($random(seed)), blk, hf, df, 2'($random(seed))};
        per = nch / nfr;
        for (int f = 0; f < nfr; f++) begin
            c0 = f * per;
            cn = (f == nfr - 1) ? nch - c0 : per;
            lst = (f == nfr - 1);
            w = {};
            w.push_back('0);
            if (f == 0) begin
                w.push_back(hw);
                exp_hdr.push_back('{1'b1, hw[0], hw[1], df & (blk != 4'h1), hf, blk != 4'h1,
                                   blk, (blk == 4'h0) ? 5'h10 : {1'b0, blk}, hw[12:8], hw[20:13]});
            end
            cur = '0;
            k = 0;
            for (int i = 0; i < cn * 4; i++) begin
                bv = ch[c0 + i / 4][i % 4];
                cur[k] = bv;
                k++;
                if (k == INFO_W) begin
                    w.push_back(cur);
                    cur = '0;
                    k = 0;
                end
            end
            // An exactly filled word needs a whole word of opposite fill after it.
            if (k == 0) cur = {INFO_W{~bv}};
            else for (int i = k; i < INFO_W; i++) cur[i] = ~bv;
            w.push_back(cur);
            fn = (f == 0 || (fault == 3 && f == 1)) ? 2'h3 : 2'((f - 1) % 3);
            fe |= (fault == 3 && f == 1);
            ks = {7'h00, num[5:1]} + {4'h0, num[0], fn, !lst, 4'h0};
            for (int j = 1; j < w.size(); j++)
                ks += {4'h0, w[j][7:0]} + {4'h0, w[j][15:8]} + {7'h00, w[j][20:16]};
            ks = ~ks ^ 12'(fault == 1 && f == 0);
            w[0] = {num, fn, !lst, ks};
            for (int i = 0; i < cn; i++) exp_chr.push_back(ch[c0 + i]);
            exp_st.push_back('{1'b1, lst, f == 0, fault == 1 && f == 0, fe, lst && fault == 2,
                              (fault == 1 && f == 0) || fe || (lst && fault == 2),
                              lst && !hf && prev_hdr && prev_num == num, num, fn});
            for (int j = 0; j < w.size(); j++) src.send(w[j], j == 0, j == w.size() - 1);
        end
        // Let an edge pass so the release and the next message's first word never share a step.
        src.rest();
        @(posedge ref_clk);
        prev_hdr = hf;
        prev_num = num;
    endtask : send_msg

    always @(negedge ref_clk) begin
        if (hdr_out.valid === 1'b1) begin
            eh = (exp_hdr.size() > 0) ? exp_hdr.pop_front() : '0;
            `CHECK("header", eh, hdr_out)
        end
        if (char_out.valid === 1'b1) begin
            ec = (exp_chr.size() > 0) ? exp_chr.pop_front() : 4'hx;
            `CHECK("character", ec, char_out.data)
        end
        if (status.done === 1'b1) begin
            es = (exp_st.size() > 0) ? exp_st.pop_front() : '0;
            `CHECK("status", es, status)
        end
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        report_and_stop();
    end

    task automatic drain();
        for (int i = 0; i < 300 && exp_st.size() > 0; i++) @(posedge ref_clk);
        @(posedge ref_clk);
    endtask : drain

    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        for (int b = 0; b < 16; b++)
            send_msg(6'(b), 4'(b), 1'b0, b[1], (b == 1 || b == 4) ? 42 : 2 + ($random(seed) & 15),
                     1 + b % 3, 0);
        $display("test blocking codes and fill done");
        send_msg(6'h14, 4'h1, 1'b1, 1'b0, 3, 1, 0);
        send_msg(6'h14, 4'h1, 1'b0, 1'b0, 9, 2, 0);
        send_msg(6'h15, 4'h4, 1'b0, 1'b1, 5, 1, 0);
        send_msg(6'h16, 4'h8, 1'b1, 1'b1, 4, 1, 0);
        send_msg(6'h17, 4'h1, 1'b0, 1'b0, 6, 1, 0);
        $display("test header linking done");
        for (int f = 1; f < 4; f++) send_msg(6'(6'h20 + f), 4'h1, 1'b0, 1'b0, 12, 2, f);
        $display("test error flags done");
        drain();
        arst_n <= 1'b0;
        @(negedge ref_clk);
        `CHECK("ready in reset", 1'b0, word_ready)
        `CHECK("status in reset", '0, status)
        @(posedge ref_clk);
        arst_n <= 1'b1;
        prev_hdr = 1'b0;
        send_msg(6'h30, 4'h1, 1'b0, 1'b0, 21, 1, 0);
        drain();
        `CHECK("pending notes", 0, exp_hdr.size() + exp_chr.size() + exp_st.size())
        $display("test reset and exact fill done");
        report_and_stop();
    end
endmodule : tb_paging_binary_message_parser
`default_nettype wire

// [verification/word_source.sv]
// Upstream code-word source model that offers words to the parser and sometimes pauses.
`timescale 1ns/100ps
`default_nettype none
module word_source
    import pager_bin_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     ready,
    output var  word_in_t word
);
    integer seed = 32'hcb3feafe;

    initial word = '0;

    // A word is held unchanged until the edge that takes it, then kept or released at random.
    task automatic send(input logic [INFO_W-1:0] info, input logic first, input logic last);
        word <= '{1'b1, first, last, info};
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        if ($random(seed) & 1) begin
            rest();
            @(posedge clk);
        end
    endtask : send

    // Released lines carry the inverse of the last word, so stale data cannot pass for new.
    task automatic rest();
        word <= '{1'b0, 1'b0, 1'b0, ~word.info};
    endtask : rest
endmodule : word_source
`default_nettype wire

// [verilog/pager_bin_pkg.sv]
// Constants and carrier types for the transparent paging message parser.
package pager_bin_pkg;
    localparam int INFO_W = 21;
    localparam int CHAR_W = 4;
    // First word of every fragment.
    localparam int POS_K_LO = 0;
    localparam int K_W = 12;
    localparam int POS_C = 12;
    localparam int POS_F_LO = 13;
    localparam int POS_N_LO = 15;
    localparam int N_W = 6;
    // Second word of a first fragment.
    localparam int POS_R = 0;
    localparam int POS_M = 1;
    localparam int POS_D = 2;
    localparam int POS_H = 3;
    localparam int POS_B_LO = 4;
    localparam int POS_RSV_LO = 8;
    localparam int POS_SIG_LO = 13;
    // Checksum byte groups of an information field.
    localparam int GRP1_LO = 8;
    localparam int GRP2_LO = 16;
    localparam logic [1:0] FRAG_FIRST = 2'h3;
    localparam logic [3:0] BLK_BINARY = 4'h1;
    localparam logic [3:0] BLK_SIXTEEN = 4'h0;
    localparam logic [4:0] BITS_SIXTEEN = 5'h10;
    localparam logic [4:0] RSV_DEFAULT = 5'h00;
    localparam logic [4:0] WORD_BITS = 5'h15;
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_HDR = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_CHECK = 2'b10
    } state_t;

    typedef struct packed {
        logic              valid;
        logic              first;
        logic              last;
        logic [INFO_W-1:0] info;
    } word_in_t;

    typedef struct packed {
        logic       valid;
        logic       retrieval;
        logic       mail_drop;
        logic       rtl;
        logic       is_header;
        logic       char_mode;
        logic [3:0] blk_code;
        logic [4:0] bits_per_char;
        logic [4:0] reserved;
        logic [7:0] signature;
    } hdr_out_t;

    typedef struct packed {
        logic              valid;
        logic [CHAR_W-1:0] data;
    } char_out_t;

    typedef struct packed {
        logic           done;
        logic           final_frag;
        logic           first_frag;
        logic           sum_err;
        logic           frag_err;
        logic           sig_err;
        logic           error;
        logic           header_link;
        logic [N_W-1:0] msg_num;
        logic [1:0]     frag_num;
    } status_t;
endpackage : pager_bin_pkg

// [verilog/paging_binary_message_parser.sv]
// Parser for transparent paging messages: headers, characters, fill and checks.
`timescale 1ns/100ps
`default_nettype none
module paging_binary_message_parser
    import pager_bin_pkg::*;
(
    input  wire logic     REF_CLK,
    input  wire logic     ARST_N,
    input  wire word_in_t WORD_IN,
    output var  logic     WORD_READY,
    output var  hdr_out_t HDR_OUT,
    output var  char_out_t CHAR_OUT,
    output var  status_t  STATUS
);
    function automatic logic [4:0] fill_len(input logic [INFO_W-1:0] w);
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < INFO_W; i++) begin
            if (w[i] != w[INFO_W-1]) begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction : fill_len

    function automatic logic [1:0] next_frag(input logic [1:0] f);
        return (f == 2'h2 || f == FRAG_FIRST) ? 2'h0 : 2'(f + 2'h1);
    endfunction : next_frag

    state_t            state_q, state_d;
    logic [1:0]        widx_q, widx_d;
    logic              ffirst_q, ffirst_d;
    logic              act_q, act_d;
    logic [1:0]        fexp_q, fexp_d;
    logic [1:0]        fnum_q, fnum_d;
    logic [N_W-1:0]    num_q, num_d;
    logic              cont_q, cont_d;
    logic [K_W-1:0]    k_q, k_d;
    logic [7:0]        sig_q, sig_d;
    logic [INFO_W-1:0] sh_q, sh_d;
    logic [4:0]        left_q, left_d;
    logic              lastw_q, lastw_d;
    logic              pol_q, pol_d;
    logic [3:0]        nib_q, nib_d;
    logic [1:0]        nbit_q, nbit_d;
    logic [3:0]        low_q, low_d;
    logic              hlow_q, hlow_d;
    logic [7:0]        ssum_q, ssum_d;
    logic              ferr_q, ferr_d;
    logic              ishdr_q, ishdr_d;
    logic              hpend_q, hpend_d;
    logic [N_W-1:0]    hnum_q, hnum_d;
    hdr_out_t          hdr_d;
    char_out_t         chr_d;
    status_t           stat_d;
    logic              acc, hdr_acc, data_acc, ctrl_acc;
    logic [3:0]        ch;
    logic [7:0]        sig_fin;
    logic [K_W-1:0]    chk_sum;
    logic [INFO_W-1:0] sum_word;

    assign acc      = WORD_IN.valid && WORD_READY;
    assign ctrl_acc = acc && widx_q == IDX_CTRL;
    assign hdr_acc  = acc && widx_q == IDX_HDR && ffirst_q;
    assign data_acc = acc && !ctrl_acc && !hdr_acc;
    // The checksum field itself counts as zero in its own sum.
    assign sum_word = ctrl_acc ? {WORD_IN.info[INFO_W-1:K_W], {K_W{1'b0}}} : WORD_IN.info;

    word_sum u_word_sum (
        .clk   (REF_CLK),
        .rst_n (ARST_N),
        .load  (ctrl_acc),
        .add   (acc && !ctrl_acc),
        .word  (sum_word),
        .sum_q (chk_sum)
    );

    always_comb begin
        state_d = state_q;  widx_d = widx_q;  ffirst_d = ffirst_q;  act_d = act_q;
        fexp_d = fexp_q;    fnum_d = fnum_q;  num_d = num_q;        cont_d = cont_q;
        k_d = k_q;          sig_d = sig_q;    sh_d = sh_q;          left_d = left_q;
        lastw_d = lastw_q;  pol_d = pol_q;    nib_d = nib_q;        nbit_d = nbit_q;
        low_d = low_q;      hlow_d = hlow_q;  ssum_d = ssum_q;      ferr_d = ferr_q;
        ishdr_d = ishdr_q;  hpend_d = hpend_q; hnum_d = hnum_q;
        hdr_d = HDR_OUT;
        hdr_d.valid = 1'b0;
        chr_d = '0;
        stat_d = '0;
        stat_d.msg_num = STATUS.msg_num;
        stat_d.frag_num = STATUS.frag_num;
        ch = {sh_q[0], nib_q[3:1]};
        sig_fin = ssum_q + (hlow_q ? {4'h0, low_q} : 8'h00);
        case (state_q)
            ST_IDLE: begin
                if (ctrl_acc) begin
                    fnum_d = WORD_IN.info[POS_F_LO +: 2];
                    num_d = WORD_IN.info[POS_N_LO +: N_W];
                    if (!act_q) begin
                        // A new message: the sequence must open on the first number.
                        ffirst_d = 1'b1;
                        ferr_d = fnum_d != FRAG_FIRST;
                        ssum_d = '0;
                        hlow_d = 1'b0;
                        nbit_d = '0;
                        ishdr_d = 1'b0;
                    end else begin
                        ffirst_d = 1'b0;
                        ferr_d = ferr_q || fnum_d != fexp_q || num_d != num_q;
                    end
                    fexp_d = next_frag(fnum_d);
                    cont_d = WORD_IN.info[POS_C];
                    k_d = WORD_IN.info[POS_K_LO +: K_W];
                    act_d = 1'b1;
                    widx_d = IDX_HDR;
                    if (WORD_IN.last) begin
                        state_d = ST_CHECK;
                    end
                end else if (hdr_acc) begin
                    hdr_d.valid = 1'b1;
                    hdr_d.retrieval = WORD_IN.info[POS_R];
                    hdr_d.mail_drop = WORD_IN.info[POS_M];
                    hdr_d.blk_code = WORD_IN.info[POS_B_LO +: 4];
                    hdr_d.char_mode = hdr_d.blk_code != BLK_BINARY;
                    hdr_d.rtl = WORD_IN.info[POS_D] && hdr_d.char_mode;
                    hdr_d.is_header = WORD_IN.info[POS_H];
                    hdr_d.bits_per_char = (hdr_d.blk_code == BLK_SIXTEEN) ?
                        BITS_SIXTEEN : {1'b0, hdr_d.blk_code};
                    hdr_d.reserved = WORD_IN.info[POS_RSV_LO +: 5];
                    hdr_d.signature = WORD_IN.info[POS_SIG_LO +: 8];
                    sig_d = hdr_d.signature;
                    ishdr_d = hdr_d.is_header;
                    widx_d = IDX_DATA;
                    if (WORD_IN.last) begin
                        state_d = ST_CHECK;
                    end
                end else if (data_acc) begin
                    // The last word carries data only below its fill; a uniform
                    // last word is pure fill and contributes no bits.
                    sh_d = WORD_IN.info;
                    left_d = WORD_IN.last ? fill_len(WORD_IN.info) : WORD_BITS;
                    lastw_d = WORD_IN.last;
                    pol_d = WORD_IN.info[INFO_W-1];
                    widx_d = IDX_DATA;
                    if (left_d != 5'h00) begin
                        state_d = ST_SHIFT;
                    end else if (WORD_IN.last) begin
                        state_d = ST_CHECK;
                    end
                end
            end
            ST_SHIFT: begin
                sh_d = sh_q >> 1;
                left_d = left_q - 5'h01;
                nib_d = ch;
                nbit_d = nbit_q + 2'h1;
                if (nbit_q == 2'h3) begin
                    chr_d.valid = 1'b1;
                    chr_d.data = ch;
                    if (hlow_q) begin
                        ssum_d = ssum_q + {ch, low_q};
                        hlow_d = 1'b0;
                    end else begin
                        low_d = ch;
                        hlow_d = 1'b1;
                    end
                end
                if (left_q == 5'h01) begin
                    state_d = lastw_q ? ST_CHECK : ST_IDLE;
                end
            end
            ST_CHECK: begin
                // Bits short of a whole character at a fragment end are fill.
                nbit_d = '0;
                widx_d = IDX_CTRL;
                stat_d.done = 1'b1;
                stat_d.final_frag = !cont_q;
                stat_d.first_frag = ffirst_q;
                stat_d.msg_num = num_q;
                stat_d.frag_num = fnum_q;
                stat_d.sum_err = K_W'(~chk_sum) != k_q;
                stat_d.frag_err = ferr_q;
                if (!cont_q) begin
                    // A lone trailing character forms a byte with a zero upper nibble.
                    stat_d.sig_err = 8'(~sig_fin) != sig_q;
                    stat_d.header_link = hpend_q && !ishdr_q && num_q == hnum_q;
                    hpend_d = ishdr_q;
                    hnum_d = num_q;
                    act_d = 1'b0;
                    hlow_d = 1'b0;
                end
                stat_d.error = stat_d.sum_err || stat_d.sig_err || stat_d.frag_err;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_IDLE;  widx_q <= IDX_CTRL; ffirst_q <= 1'b0; act_q <= 1'b0;
            fexp_q <= FRAG_FIRST; fnum_q <= '0;      num_q <= '0;      cont_q <= 1'b0;
            k_q <= '0;           sig_q <= '0;       sh_q <= '0;       left_q <= '0;
            lastw_q <= 1'b0;     pol_q <= 1'b0;     nib_q <= '0;      nbit_q <= '0;
            low_q <= '0;         hlow_q <= 1'b0;    ssum_q <= '0;     ferr_q <= 1'b0;
            ishdr_q <= 1'b0;     hpend_q <= 1'b0;   hnum_q <= '0;
            WORD_READY <= 1'b0;
            HDR_OUT <= '0;
            CHAR_OUT <= '0;
            STATUS <= '0;
        end else begin
            state_q <= state_d;  widx_q <= widx_d;  ffirst_q <= ffirst_d; act_q <= act_d;
            fexp_q <= fexp_d;    fnum_q <= fnum_d;  num_q <= num_d;       cont_q <= cont_d;
            k_q <= k_d;          sig_q <= sig_d;    sh_q <= sh_d;         left_q <= left_d;
            lastw_q <= lastw_d;  pol_q <= pol_d;    nib_q <= nib_d;       nbit_q <= nbit_d;
            low_q <= low_d;      hlow_q <= hlow_d;  ssum_q <= ssum_d;     ferr_q <= ferr_d;
            ishdr_q <= ishdr_d;  hpend_q <= hpend_d; hnum_q <= hnum_d;
            WORD_READY <= state_d == ST_IDLE;
            HDR_OUT <= hdr_d;
            CHAR_OUT <= chr_d;
            STATUS <= stat_d;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    property p_rtl;
        hdr_acc |=> HDR_OUT.rtl == ($past(WORD_IN.info[POS_D]) && HDR_OUT.blk_code != BLK_BINARY);
    endproperty
    a_rtl: assert property (p_rtl) else $error("direction flag wrong");
    property p_hdr_flag;
        hdr_acc |=> HDR_OUT.valid && HDR_OUT.is_header == $past(WORD_IN.info[POS_H]);
    endproperty
    a_hdr_flag: assert property (p_hdr_flag) else $error("header flag wrong");
    property p_bpc;
        HDR_OUT.valid |-> HDR_OUT.bits_per_char ==
            ((HDR_OUT.blk_code == 4'h0) ? 5'h10 : {1'b0, HDR_OUT.blk_code});
    endproperty
    a_bpc: assert property (p_bpc) else $error("bits per character wrong");
    property p_mode;
        HDR_OUT.valid |-> HDR_OUT.char_mode == (HDR_OUT.blk_code != 4'h1);
    endproperty
    a_mode: assert property (p_mode) else $error("character mode wrong");
    property p_rsv;
        hdr_acc |=> HDR_OUT.reserved == $past(WORD_IN.info[POS_RSV_LO +: 5]);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved field altered");
    property p_sig;
        (state_q == ST_CHECK && !cont_q) |=> STATUS.sig_err == (8'(~$past(sig_fin)) != $past(sig_q));
    endproperty
    a_sig: assert property (p_sig) else $error("signature check wrong");
    property p_pair;
        (state_q == ST_SHIFT && nbit_q == 2'h3 && hlow_q)
            |=> ssum_q == 8'($past(ssum_q) + {CHAR_OUT.data, $past(low_q)});
    endproperty
    a_pair: assert property (p_pair) else $error("byte pairing wrong");
    property p_fill;
        (state_q == ST_SHIFT && lastw_q && left_q == 5'h01) |-> sh_q[0] != pol_q;
    endproperty
    a_fill: assert property (p_fill) else $error("data ran into fill");
    property p_extra;
        (data_acc && WORD_IN.last && (&WORD_IN.info || ~|WORD_IN.info)) |=> state_q == ST_CHECK;
    endproperty
    a_extra: assert property (p_extra) else $error("extra fill word not ended");
    property p_sum;
        STATUS.done |-> STATUS.sum_err == (K_W'(~chk_sum) != k_q);
    endproperty
    a_sum: assert property (p_sum) else $error("checksum verdict wrong");
    property p_first;
        (STATUS.done && STATUS.first_frag && !STATUS.frag_err) |-> STATUS.frag_num == 2'h3;
    endproperty
    a_first: assert property (p_first) else $error("first fragment number wrong");
    property p_err;
        STATUS.done |-> STATUS.error == (STATUS.sum_err || STATUS.sig_err || STATUS.frag_err);
    endproperty
    a_err: assert property (p_err) else $error("error not raised");
    property p_link;
        STATUS.header_link |-> STATUS.final_frag && STATUS.msg_num == $past(hnum_q);
    endproperty
    a_link: assert property (p_link) else $error("header link wrong");

    c_link: cover property (STATUS.header_link);
    c_sig_err: cover property (STATUS.done && STATUS.sig_err);
    c_multi: cover property (STATUS.done && STATUS.final_frag && !STATUS.first_frag);
    c_extra: cover property (data_acc && WORD_IN.last && ~|WORD_IN.info);
endmodule : paging_binary_message_parser
`default_nettype wire

// [verilog/word_sum.sv]
// Fragment checksum accumulator over the three byte groups of each word.
`timescale 1ns/100ps
`default_nettype none
module word_sum
    import pager_bin_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              load,
    input  wire logic              add,
    input  wire logic [INFO_W-1:0] word,
    output var  logic [K_W-1:0]    sum_q
);
    logic [K_W-1:0] grp;
    logic [K_W-1:0] sum_d;

    always_comb begin
        grp = K_W'(word[GRP1_LO-1:0]) + K_W'(word[GRP2_LO-1:GRP1_LO])
            + K_W'(word[INFO_W-1:GRP2_LO]);
        sum_d = sum_q;
        if (load) begin
            sum_d = grp;
        end else if (add) begin
            sum_d = sum_q + grp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_q <= '0;
        end else begin
            sum_q <= sum_d;
        end
    end
endmodule : word_sum
`default_nettype wire
